// *** shared/arlz_defs.vh ***
// Register map, field layout, reset values and codes of the result limit and sign-change block.
`ifndef ARLZ_DEFS_VH
`define ARLZ_DEFS_VH

`define ARLZ_ADDR_W       8
`define ARLZ_SLOTS        8

`define ARLZ_CTRL_OFS     8'h00
`define ARLZ_SUMM_OFS     8'h04
`define ARLZ_LSTAT_OFS    8'h08
`define ARLZ_ZSTAT_OFS    8'h0c
`define ARLZ_EDGE_OFS     8'h10

`define ARLZ_RES_REGION   3'h2
`define ARLZ_LLIM_REGION  3'h3
`define ARLZ_HLIM_REGION  3'h4
`define ARLZ_OFFS_REGION  3'h5

`define ARLZ_CTRL_HIE     0
`define ARLZ_CTRL_LIE     1
`define ARLZ_CTRL_ZIE     2
`define ARLZ_CTRL_RST     3'h0
`define ARLZ_EDGE_RST     16'h0000

`define ARLZ_HLIM_RST     16'h7ff8
`define ARLZ_LLIM_RST     16'h0000
`define ARLZ_OFFS_RST     16'h0000
`define ARLZ_RES_RST      16'h0000
`define ARLZ_FIELD_MASK   16'h7ff8
`define ARLZ_FIELD_MSB    14
`define ARLZ_FIELD_LSB    3
`define ARLZ_HLS_LSB      8

`define ARLZ_EDGE_OFF     2'b00
`define ARLZ_EDGE_FALL    2'b01
`define ARLZ_EDGE_RISE    2'b10
`define ARLZ_EDGE_ANY     2'b11

`define ARLZ_RESP_OKAY    2'b00
`define ARLZ_RESP_SLVERR  2'b10

`endif

// *** design/arlz_slot_eval.v ***
// Offset subtraction, limit comparison and sign-change detection for one sample.
`timescale 1ns/1ps
`include "arlz_defs.vh"
module arlz_slot_eval (
  input  wire [15:0] raw,
  input  wire [15:0] offset,
  input  wire [15:0] lower,
  input  wire [15:0] upper,
  input  wire [1:0]  edge_sel,
  input  wire        prev_sign,
  output wire [15:0] result,
  output wire        over,
  output wire        under,
  output wire        crossed
);
  wire [11:0] raw_f;
  wire [11:0] off_f;
  wire [12:0] diff;

  assign raw_f  = raw[`ARLZ_FIELD_MSB:`ARLZ_FIELD_LSB];
  assign off_f  = offset[`ARLZ_FIELD_MSB:`ARLZ_FIELD_LSB];
  // The sign of the stored value is the borrow of this subtraction and nothing else.
  assign diff   = {1'b0, raw_f} - {1'b0, off_f};
  assign result = {diff, 3'b000};

  // Limits look at the raw value, before the offset is taken off.
  assign over   = raw_f > upper[`ARLZ_FIELD_MSB:`ARLZ_FIELD_LSB];
  assign under  = raw_f < lower[`ARLZ_FIELD_MSB:`ARLZ_FIELD_LSB];

  // Bit 0 of the edge setting catches positive to negative, bit 1 negative to positive.
  assign crossed = (edge_sel[0] & ~prev_sign & diff[12]) |
                   (edge_sel[1] & prev_sign & ~diff[12]);
endmodule

// *** design/arlz_result_mem.v ***
// Eight-word result store with one write port and a registered read port.
`timescale 1ns/1ps
`include "arlz_defs.vh"
module arlz_result_mem (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        ce,
  input  wire        we,
  input  wire [2:0]  waddr,
  input  wire [15:0] wdata,
  input  wire [2:0]  raddr,
  output reg  [15:0] rdata
);
  wire [15:0] word_w [0:`ARLZ_SLOTS-1];

  genvar g;
  generate
    for (g = 0; g < `ARLZ_SLOTS; g = g + 1) begin : g_word
      localparam [2:0] IDX = g;
      reg [15:0] word_r;
      always @(posedge aclk) begin
        if (!aresetn) begin
          word_r <= `ARLZ_RES_RST;
        end else if (ce && we && waddr == IDX) begin
          word_r <= wdata;
        end
      end
      assign word_w[g] = word_r;
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn) begin
      rdata <= `ARLZ_RES_RST;
    end else if (ce) begin
      rdata <= word_w[raddr];
    end
  end
endmodule

// *** design/arlz_top.v ***
// Result post-processing: offset correction, limit and sign-change flags, AXI4-Lite register slave.
//
// What this block does
// - Set upper violation bit n when raw sample n exceeds its upper bound.
// - Set lower violation bit n when raw sample n is below its lower bound.
// - Violation and sign-change bits stay set until software writes one to them.
// - Upper violations raise the interrupt only when their enable bit is set.
// - Set sign-change bit n on a sign flip in the selected direction; 0b11 either.
// - Sign changes raise the interrupt only when their enable bit is set.
// - Sign-change bits sit in 7..0; disabled or unchanged slots never set them.
// - Eight result registers; slot n's conversion lands in result register n.
// - Parallel pair slots zero and four land in result registers zero and four.
// - Software result writes use bits 14..3, subtract the offset, store the difference.
// - Result bit 15 is the sign, one negative, in two's complement.
// - Result bits 2..0 always read zero; the value is left-justified by three.
// - Limit checks use the raw value, not the offset-corrected one.
// - Every slot has its own lower and upper bound pair.
// - After reset the bounds disable checking, so no violation bit sets.
// - Lower summary flag clears only when every lower violation bit is cleared.
// - Sign-change summary flag clears only when every sign-change bit is cleared.
// - Each sample has its slot offset subtracted before being stored.
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "arlz_defs.vh"
module arlz_top (
  input  wire                    aclk,
  input  wire                    aresetn,
  input  wire                    ce,
  input  wire                    smp_valid,
  input  wire [2:0]              smp_slot,
  input  wire [15:0]             smp_raw,
  input  wire [`ARLZ_ADDR_W-1:0] s_axi_awaddr,
  input  wire                    s_axi_awvalid,
  output reg                     s_axi_awready,
  input  wire [31:0]             s_axi_wdata,
  input  wire [3:0]              s_axi_wstrb,
  input  wire                    s_axi_wvalid,
  output reg                     s_axi_wready,
  output reg  [1:0]              s_axi_bresp,
  output reg                     s_axi_bvalid,
  input  wire                    s_axi_bready,
  input  wire [`ARLZ_ADDR_W-1:0] s_axi_araddr,
  input  wire                    s_axi_arvalid,
  output reg                     s_axi_arready,
  output reg  [31:0]             s_axi_rdata,
  output reg  [1:0]              s_axi_rresp,
  output reg                     s_axi_rvalid,
  input  wire                    s_axi_rready,
  output reg                     irq
);
  localparam [1:0] W_IDLE = 2'd0;
  localparam [1:0] W_PEND = 2'd1;
  localparam [1:0] W_RESP = 2'd2;
  localparam [1:0] R_IDLE = 2'd0;
  localparam [1:0] R_MEM  = 2'd1;
  localparam [1:0] R_DATA = 2'd2;
  localparam [1:0] R_RESP = 2'd3;

  reg  [1:0]              wst_r;
  reg  [1:0]              rst_r;
  reg  [`ARLZ_ADDR_W-1:0] wr_addr_r;
  reg  [15:0]             wr_data_r;
  reg  [1:0]              wr_strb_r;
  reg  [`ARLZ_ADDR_W-1:0] rd_addr_r;
  reg  [2:0]              ctrl_r;
  reg  [15:0]             edge_r;

  wire [15:0] lo_w   [0:`ARLZ_SLOTS-1];
  wire [15:0] hi_w   [0:`ARLZ_SLOTS-1];
  wire [15:0] off_w  [0:`ARLZ_SLOTS-1];
  wire [7:0]  sign_w;
  wire [7:0]  hls_w;
  wire [7:0]  lls_w;
  wire [7:0]  zcs_w;
  wire [15:0] lstat_w;
  wire [15:0] zstat_w;
  wire [2:0]  summ_w;
  wire [15:0] smp_result;
  wire        smp_over;
  wire        smp_under;
  wire        smp_cross;
  wire [15:0] sw_result;
  wire [15:0] mem_rdata;
  wire [15:0] wr_merged;

  wire [2:0] wr_region = wr_addr_r[7:5];
  wire [2:0] wr_slot   = wr_addr_r[4:2];
  wire [2:0] rd_region = rd_addr_r[7:5];
  wire [2:0] rd_slot   = rd_addr_r[4:2];
  wire [7:0] wr_word   = {wr_addr_r[7:2], 2'b00};
  wire [7:0] rd_word   = {rd_addr_r[7:2], 2'b00};

  wire wr_is_res  = wr_region == `ARLZ_RES_REGION;
  wire wr_is_lo   = wr_region == `ARLZ_LLIM_REGION;
  wire wr_is_hi   = wr_region == `ARLZ_HLIM_REGION;
  wire wr_is_off  = wr_region == `ARLZ_OFFS_REGION;
  wire wr_is_ctrl = wr_word == `ARLZ_CTRL_OFS;
  wire wr_is_summ = wr_word == `ARLZ_SUMM_OFS;
  wire wr_is_lst  = wr_word == `ARLZ_LSTAT_OFS;
  wire wr_is_zst  = wr_word == `ARLZ_ZSTAT_OFS;
  wire wr_is_edge = wr_word == `ARLZ_EDGE_OFS;
  wire wr_mapped  = wr_is_res | wr_is_lo | wr_is_hi | wr_is_off |
                    wr_is_ctrl | wr_is_summ | wr_is_lst | wr_is_zst | wr_is_edge;

  // A sample owns the result store's write port; a software result write waits in W_PEND while smp_valid is high.
  wire wr_conflict = wr_is_res & smp_valid;
  wire wr_do       = (wst_r == W_PEND) & ~wr_conflict;

  // Write-one-to-clear masks honour the byte strobes.
  wire [15:0] w1c_mask = {wr_data_r[15:8] & {8{wr_strb_r[1]}}, wr_data_r[7:0] & {8{wr_strb_r[0]}}};
  wire        clr_lst  = wr_do & wr_is_lst;
  wire        clr_zst  = wr_do & wr_is_zst;

  assign wr_merged = wr_data_r;

  function [15:0] arlz_merge;
    input [15:0] old_v;
    input [15:0] new_v;
    input [1:0]  strb;
    begin
      arlz_merge = {strb[1] ? new_v[15:8] : old_v[15:8], strb[0] ? new_v[7:0] : old_v[7:0]};
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < `ARLZ_SLOTS; g = g + 1) begin : g_slot
      localparam [2:0] IDX = g;
      reg  [15:0] lo_r;
      reg  [15:0] hi_r;
      reg  [15:0] off_r;
      reg         sign_r;
      reg         hls_r;
      reg         lls_r;
      reg         zcs_r;
      wire        hit = smp_valid & (smp_slot == IDX);

      always @(posedge aclk) begin
        if (!aresetn) begin
          lo_r   <= `ARLZ_LLIM_RST;
          hi_r   <= `ARLZ_HLIM_RST;
          off_r  <= `ARLZ_OFFS_RST;
          sign_r <= 1'b0;
          hls_r  <= 1'b0;
          lls_r  <= 1'b0;
          zcs_r  <= 1'b0;
        end else if (ce) begin
          if (wr_do && wr_is_lo && wr_slot == IDX) begin
            lo_r <= arlz_merge(lo_r, wr_merged, wr_strb_r) & `ARLZ_FIELD_MASK;
          end
          if (wr_do && wr_is_hi && wr_slot == IDX) begin
            hi_r <= arlz_merge(hi_r, wr_merged, wr_strb_r) & `ARLZ_FIELD_MASK;
          end
          if (wr_do && wr_is_off && wr_slot == IDX) begin
            off_r <= arlz_merge(off_r, wr_merged, wr_strb_r) & `ARLZ_FIELD_MASK;
          end
          if (hit) begin
            sign_r <= smp_result[15];
          end
          // Set takes precedence over a simultaneous write-one clear.
          hls_r <= (hls_r & ~(clr_lst & w1c_mask[`ARLZ_HLS_LSB+g])) | (hit & smp_over);
          lls_r <= (lls_r & ~(clr_lst & w1c_mask[g])) | (hit & smp_under);
          zcs_r <= (zcs_r & ~(clr_zst & w1c_mask[g])) | (hit & smp_cross);
        end
      end

      assign lo_w[g]   = lo_r;
      assign hi_w[g]   = hi_r;
      assign off_w[g]  = off_r;
      assign sign_w[g] = sign_r;
      assign hls_w[g]  = hls_r;
      assign lls_w[g]  = lls_r;
      assign zcs_w[g]  = zcs_r;
    end
  endgenerate

  assign lstat_w = {hls_w, lls_w};
  assign zstat_w = {8'h00, zcs_w};
  // Summary flags are the OR of their status bits, so they fall only once all are cleared.
  assign summ_w  = {|zcs_w, |lls_w, |hls_w};

  arlz_slot_eval u_smp_eval (
    .raw       (smp_raw),
    .offset    (off_w[smp_slot]),
    .lower     (lo_w[smp_slot]),
    .upper     (hi_w[smp_slot]),
    .edge_sel  (edge_r[2*smp_slot +: 2]),
    .prev_sign (sign_w[smp_slot]),
    .result    (smp_result),
    .over      (smp_over),
    .under     (smp_under),
    .crossed   (smp_cross)
  );

  arlz_slot_eval u_sw_eval (
    .raw       (wr_data_r),
    .offset    (off_w[wr_slot]),
    .lower     (lo_w[wr_slot]),
    .upper     (hi_w[wr_slot]),
    .edge_sel  (`ARLZ_EDGE_OFF),
    .prev_sign (1'b0),
    .result    (sw_result),
    .over      (),
    .under     (),
    .crossed   ()
  );

  // The slot tag addresses the store, so paired slots zero and four land in words zero and four.
  arlz_result_mem u_mem (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .we      (smp_valid | (wr_do & wr_is_res)),
    .waddr   (smp_valid ? smp_slot : wr_slot),
    .wdata   (smp_valid ? smp_result : sw_result),
    .raddr   (rd_slot),
    .rdata   (mem_rdata)
  );

  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `ARLZ_CTRL_RST;
      edge_r <= `ARLZ_EDGE_RST;
      irq    <= 1'b0;
    end else if (ce) begin
      if (wr_do && wr_is_ctrl && wr_strb_r[0]) begin
        ctrl_r <= wr_data_r[2:0];
      end
      if (wr_do && wr_is_edge) begin
        edge_r <= arlz_merge(edge_r, wr_merged, wr_strb_r);
      end
      irq <= (ctrl_r[`ARLZ_CTRL_HIE] & summ_w[0]) |
             (ctrl_r[`ARLZ_CTRL_LIE] & summ_w[1]) |
             (ctrl_r[`ARLZ_CTRL_ZIE] & summ_w[2]);
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      wst_r         <= W_IDLE;
      wr_addr_r     <= {`ARLZ_ADDR_W{1'b0}};
      wr_data_r     <= 16'h0000;
      wr_strb_r     <= 2'b00;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ARLZ_RESP_OKAY;
    end else if (ce) begin
      case (wst_r)
        W_IDLE: begin
          if (s_axi_awvalid && s_axi_wvalid) begin
            wr_addr_r     <= s_axi_awaddr;
            wr_data_r     <= s_axi_wdata[15:0];
            wr_strb_r     <= s_axi_wstrb[1:0];
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            wst_r         <= W_PEND;
          end
        end
        W_PEND: begin
          s_axi_awready <= 1'b0;
          s_axi_wready  <= 1'b0;
          if (!wr_conflict) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? `ARLZ_RESP_OKAY : `ARLZ_RESP_SLVERR;
            wst_r        <= W_RESP;
          end
        end
        W_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wst_r        <= W_IDLE;
          end
        end
        default: begin
          wst_r <= W_IDLE;
        end
      endcase
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rst_r         <= R_IDLE;
      rd_addr_r     <= {`ARLZ_ADDR_W{1'b0}};
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `ARLZ_RESP_OKAY;
    end else if (ce) begin
      case (rst_r)
        R_IDLE: begin
          if (s_axi_arvalid) begin
            rd_addr_r     <= s_axi_araddr;
            s_axi_arready <= 1'b1;
            rst_r         <= R_MEM;
          end
        end
        R_MEM: begin
          s_axi_arready <= 1'b0;
          rst_r         <= R_DATA;
        end
        R_DATA: begin
          s_axi_rvalid <= 1'b1;
          s_axi_rresp  <= `ARLZ_RESP_OKAY;
          rst_r        <= R_RESP;
          case (rd_region)
            `ARLZ_RES_REGION:  s_axi_rdata <= {16'h0000, mem_rdata};
            `ARLZ_LLIM_REGION: s_axi_rdata <= {16'h0000, lo_w[rd_slot]};
            `ARLZ_HLIM_REGION: s_axi_rdata <= {16'h0000, hi_w[rd_slot]};
            `ARLZ_OFFS_REGION: s_axi_rdata <= {16'h0000, off_w[rd_slot]};
            default: begin
              if (rd_word == `ARLZ_CTRL_OFS) begin
                s_axi_rdata <= {29'h0000_0000, ctrl_r};
              end else if (rd_word == `ARLZ_SUMM_OFS) begin
                s_axi_rdata <= {29'h0000_0000, summ_w};
              end else if (rd_word == `ARLZ_LSTAT_OFS) begin
                s_axi_rdata <= {16'h0000, lstat_w};
              end else if (rd_word == `ARLZ_ZSTAT_OFS) begin
                s_axi_rdata <= {16'h0000, zstat_w};
              end else if (rd_word == `ARLZ_EDGE_OFS) begin
                s_axi_rdata <= {16'h0000, edge_r};
              end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `ARLZ_RESP_SLVERR;
              end
            end
          endcase
        end
        R_RESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rst_r        <= R_IDLE;
          end
        end
        default: begin
          rst_r <= R_IDLE;
        end
      endcase
    end
  end
endmodule

// *** test/arlz_monitor.sv ***
// Port-level checks of the register handshakes and result word format.
`timescale 1ns/1ps
`include "arlz_defs.vh"
module arlz_monitor (
  input wire                    aclk,
  input wire                    aresetn,
  input wire                    s_axi_awvalid,
  input wire                    s_axi_awready,
  input wire                    s_axi_wvalid,
  input wire                    s_axi_wready,
  input wire                    s_axi_bvalid,
  input wire                    s_axi_bready,
  input wire [`ARLZ_ADDR_W-1:0] s_axi_araddr,
  input wire                    s_axi_arvalid,
  input wire                    s_axi_arready,
  input wire [31:0]             s_axi_rdata,
  input wire                    s_axi_rvalid,
  input wire                    s_axi_rready
);
  reg [`ARLZ_ADDR_W-1:0] ra_r;
  always @(posedge aclk)
    if (s_axi_arvalid && s_axi_arready)
      ra_r <= s_axi_araddr;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_aw_taken;
    s_axi_awready && s_axi_wready;
  endsequence
  sequence s_ar_taken;
    s_axi_arready ##1 !s_axi_arready;
  endsequence
  a_aw_cause: assert property (s_axi_awready |-> $past(s_axi_awvalid && s_axi_wvalid))
    else $error("awready without both valids");
  a_aw_pair: assert property (s_axi_awready == s_axi_wready)
    else $error("awready and wready differ");
  a_aw_pulse: assert property (s_aw_taken |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  a_b_follows: assert property (s_aw_taken |=> ##[0:8] s_axi_bvalid)
    else $error("write response missing");
  a_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid kept after acceptance");
  a_r_latency: assert property (s_ar_taken |=> s_axi_rvalid)
    else $error("read data late");
  a_r_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid kept after acceptance");
  a_res_low_zero: assert property (s_axi_rvalid && ra_r[7:5] == `ARLZ_RES_REGION |-> s_axi_rdata[2:0] == 3'h0)
    else $error("result low bits not zero");
  a_zc_high_zero: assert property (s_axi_rvalid && ra_r == `ARLZ_ZSTAT_OFS |-> s_axi_rdata[15:8] == 8'h00)
    else $error("sign change upper byte not zero");
endmodule
bind arlz_top arlz_monitor u_mon (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// *** test/arlz_scan_model.sv ***
// Scan sequencer model delivering tagged raw samples.
`timescale 1ns/1ps
module arlz_scan_model (
  input  wire        aclk,
  output reg         smp_valid,
  output reg  [2:0]  smp_slot,
  output reg  [15:0] smp_raw
);
  initial begin
    smp_valid = 1'b0;
    smp_slot = 3'h0;
    smp_raw = 16'h0000;
  end
  // Between samples the bus shows inverted data so stale values are never trusted.
  task send(input [2:0] slot, input [15:0] raw);
    begin
      @(posedge aclk);
      smp_valid <= 1'b1;
      smp_slot <= slot;
      smp_raw <= raw;
      @(posedge aclk);
      smp_valid <= 1'b0;
      smp_slot <= ~slot;
      smp_raw <= ~raw;
    end
  endtask
endmodule

// *** test/tb.sv ***
// Register-level tests of the result limit and sign-change block.
`timescale 1ns/1ps
`include "arlz_defs.vh"
module tb;
  localparam [1:0] OK = `ARLZ_RESP_OKAY;
  localparam [1:0] SE = `ARLZ_RESP_SLVERR;
  reg         aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
  reg  [7:0]  awaddr, araddr;
  reg  [31:0] wdata;
  reg  [3:0]  wstrb;
  wire        awready, wready, bvalid, arready, rvalid, irq, smp_valid;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [2:0]  smp_slot;
  wire [15:0] smp_raw;
  integer     err_count, n_compared, m;
  arlz_scan_model sm (.aclk(aclk), .smp_valid(smp_valid), .smp_slot(smp_slot), .smp_raw(smp_raw));
  arlz_top dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .smp_valid(smp_valid), .smp_slot(smp_slot),
    .smp_raw(smp_raw), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task chk(input [33:0] s, input [33:0] e);
    begin
      n_compared = n_compared + 1;
      if (s !== e) begin
        err_count = err_count + 1;
        $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task wr(input [7:0] a, input [15:0] d, input [1:0] er);
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(posedge aclk); while (!(awready && wready));
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b0;
      chk({32'h0, bresp}, {32'h0, er});
    end
  endtask
  task rdc(input [7:0] a, input [15:0] e, input [1:0] er);
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      rready <= 1'b0;
      chk({rresp, rdata}, {er, 16'h0000, e});
    end
  endtask
  task irq_is(input e);
    begin
      repeat (3) @(posedge aclk);
      chk({33'h0, irq}, {33'h0, e});
    end
  endtask
  task test_done;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    err_count = err_count + 1;
    test_done;
  end
  initial begin
    err_count = 0;
    n_compared = 0;
    aresetn = 1'b0;
    ce = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h3;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(8'h80, 16'h7ff8, OK);
    rdc(8'h9c, 16'h7ff8, OK);
    rdc(8'h60, 16'h0000, OK);
    rdc(8'h08, 16'h0000, OK);
    rdc(8'hfc, 16'h0000, SE);
    wr(8'hfc, 16'h1234, SE);
    $display("test reset done");
    wr(8'ha8, 16'h0100, OK);
    sm.send(3'h2, 16'h0087);
    rdc(8'h48, 16'hff80, OK);
    wr(8'h48, 16'h8307, OK);
    rdc(8'h48, 16'h0200, OK);
    sm.send(3'h0, 16'h1238);
    sm.send(3'h4, 16'h2468);
    rdc(8'h40, 16'h1238, OK);
    rdc(8'h50, 16'h2468, OK);
    // A sample offered while the clock enable is low must leave the result store untouched.
    @(posedge aclk);
    ce <= 1'b0;
    sm.send(3'h0, 16'h0ff8);
    @(posedge aclk);
    ce <= 1'b1;
    rdc(8'h40, 16'h1238, OK);
    $display("test results done");
    wr(8'h64, 16'h1000, OK);
    wr(8'h84, 16'h4000, OK);
    wr(8'ha4, 16'h3000, OK);
    sm.send(3'h1, 16'h4000);
    sm.send(3'h1, 16'h1000);
    rdc(8'h08, 16'h0000, OK);
    sm.send(3'h1, 16'h4008);
    sm.send(3'h1, 16'h0ff8);
    rdc(8'h08, 16'h0202, OK);
    irq_is(1'b0);
    wr(8'h00, 16'h0001, OK);
    irq_is(1'b1);
    sm.send(3'h1, 16'h2000);
    rdc(8'h08, 16'h0202, OK);
    // The clear lands on the same edge as a new upper violation of slot one, so the bit must stay set.
    fork
      wr(8'h08, 16'h0200, OK);
      begin
        @(posedge aclk);
        sm.send(3'h1, 16'h4008);
      end
    join
    rdc(8'h08, 16'h0202, OK);
    wr(8'h08, 16'h0200, OK);
    rdc(8'h08, 16'h0002, OK);
    rdc(8'h04, 16'h0002, OK);
    irq_is(1'b0);
    wr(8'h08, 16'h0002, OK);
    rdc(8'h04, 16'h0000, OK);
    wr(8'h64, 16'h0000, OK);
    wr(8'h84, 16'h7ff8, OK);
    sm.send(3'h1, 16'h7ff8);
    sm.send(3'h1, 16'h0000);
    rdc(8'h08, 16'h0000, OK);
    $display("test limits done");
    wr(8'hac, 16'h4000, OK);
    wr(8'h00, 16'h0004, OK);
    for (m = 0; m < 4; m = m + 1) begin
      wr(8'h10, {8'h00, m[1:0], 6'h00}, OK);
      sm.send(3'h3, 16'h6000);
      wr(8'h0c, 16'h00ff, OK);
      sm.send(3'h3, 16'h2000);
      rdc(8'h0c, {12'h0, m[0], 3'h0}, OK);
      wr(8'h0c, 16'h00ff, OK);
      sm.send(3'h3, 16'h6000);
      rdc(8'h0c, {12'h0, m[1], 3'h0}, OK);
    end
    irq_is(1'b1);
    rdc(8'h04, 16'h0004, OK);
    wr(8'h0c, 16'h0008, OK);
    rdc(8'h04, 16'h0000, OK);
    irq_is(1'b0);
    $display("test sign change done");
    test_done;
  end
endmodule
